// [rtl/icc_pkg.sv]
// Constants, field positions and carrier types for the input capture channel
package icc_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W         = 2;
  localparam int          DATA_W         = 16;
  localparam logic [1:0]  ADDR_CTRL      = 2'h0;
  localparam logic [1:0]  ADDR_CAPBUF    = 2'h1;
  localparam logic [1:0]  ADDR_INT_STAT  = 2'h2;
  localparam logic [1:0]  ADDR_INT_MASK  = 2'h3;

  // ---------------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------------
  localparam int BIT_STOP_IDLE  = 13;
  localparam int BIT_TMR_SEL    = 7;
  localparam int BIT_CPI_HI     = 6;
  localparam int BIT_CPI_LO     = 5;
  localparam int BIT_OVF        = 4;
  localparam int BIT_BNE        = 3;
  localparam int BIT_MODE_HI    = 2;
  localparam int BIT_MODE_LO    = 0;

  // Capture mode codes
  localparam logic [2:0] MODE_OFF        = 3'h0;
  localparam logic [2:0] MODE_EVERY_EDGE = 3'h1;
  localparam logic [2:0] MODE_FALL       = 3'h2;
  localparam logic [2:0] MODE_RISE       = 3'h3;
  localparam logic [2:0] MODE_RISE_4     = 3'h4;
  localparam logic [2:0] MODE_RISE_16    = 3'h5;
  localparam logic [2:0] MODE_UNUSED     = 3'h6;
  localparam logic [2:0] MODE_WAKE       = 3'h7;

  // Prescaler terminal counts (edges minus one)
  localparam logic [3:0] PRESC_LAST_4    = 4'h3;
  localparam logic [3:0] PRESC_LAST_16   = 4'hf;

  // ---------------------------------------------------------------------------
  // Buffer and interrupt layout
  // ---------------------------------------------------------------------------
  localparam int          FIFO_DEPTH     = 4;
  localparam int          PTR_W          = 2;
  localparam int          CNT_W          = 3;
  localparam logic [2:0]  FIFO_FULL_CNT  = 3'h4;
  localparam int          INT_CAPTURE    = 0;
  localparam int          INT_OVERFLOW   = 1;
  localparam int          INT_WAKE       = 2;
  localparam int          INT_W          = 3;

  // Reset values
  localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;
  localparam logic [INT_W-1:0]  RST_INT  = 3'h0;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       stop_in_idle;
    logic       timer_select;
    logic [1:0] captures_per_interrupt;
    logic [2:0] capture_mode_select;
  } icc_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } icc_bus_req_t;

  typedef struct packed {
    logic              cpu_idle;
    logic              cpu_sleep;
  } icc_power_t;

  typedef struct packed {
    icc_ctrl_t                          ctrl;
    logic [FIFO_DEPTH-1:0][DATA_W-1:0]  fifo;
    logic [PTR_W-1:0]                   wr_ptr;
    logic [PTR_W-1:0]                   rd_ptr;
    logic [CNT_W-1:0]                   count;
    logic                               overflow;
    logic                               pin_prev;
    logic [3:0]                         presc;
    logic [1:0]                         decim;
    logic [INT_W-1:0]                   int_status;
    logic [INT_W-1:0]                   int_mask;
    logic [DATA_W-1:0]                  rdata;
  } icc_state_t;

endpackage

// [rtl/icc_capture.sv]
// Input capture channel: edge detect, prescale, capture buffer, registers, interrupt
//
// Contract
// - With stop_in_idle set, the channel halts during CPU idle; otherwise it runs.
// - timer_select 1 captures the second timer, 0 captures the third timer.
// - captures_per_interrupt 00..11 raises interrupt every first..fourth capture.
// - Read-only overflow flag at bit 4; writes ignored, hardware clears it.
// - Read-only buffer-not-empty flag at bit 3; high while unread captures remain.
// - Mode 111 is only a rising-edge wake interrupt in sleep or idle.
// - Mode 101 captures every sixteenth rising edge, mode 100 every fourth.
// - Mode 011 captures every rising edge, mode 010 every falling edge.
// - An every-edge mode exists; captures_per_interrupt does not govern it.
// - Mode 000 turns the channel off; unused mode 110 also disables it.
// - Unimplemented control bits 15-14 and 12-8 always read zero.
//
// Design decisions made here: strobed register access and the placing of the registers.
module icc_capture
  import icc_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire icc_pkg::icc_bus_req_t    bus_req,
  output logic [icc_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic                     cap_pin,
  input  wire logic [icc_pkg::DATA_W-1:0] second_general_timer,
  input  wire logic [icc_pkg::DATA_W-1:0] third_general_timer,
  input  wire icc_pkg::icc_power_t      power,
  output logic                          irq
);
  import icc_pkg::*;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic mode_is_off(input logic [2:0] m);
    return (m == MODE_OFF) || (m == MODE_UNUSED);
  endfunction

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return p + PTR_W'(1);
  endfunction

  function automatic logic [DATA_W-1:0] ctrl_image(input icc_state_t st);
    logic [DATA_W-1:0] v;
    v = RST_DATA;
    v[BIT_STOP_IDLE]             = st.ctrl.stop_in_idle;
    v[BIT_TMR_SEL]               = st.ctrl.timer_select;
    v[BIT_CPI_HI:BIT_CPI_LO]     = st.ctrl.captures_per_interrupt;
    v[BIT_OVF]                   = st.overflow;
    v[BIT_BNE]                   = (st.count != '0);
    v[BIT_MODE_HI:BIT_MODE_LO]   = st.ctrl.capture_mode_select;
    return v;
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  icc_state_t s_reg;
  icc_state_t s_next;

  logic [2:0]        mode;
  logic              halted;
  logic              rise;
  logic              fall;
  logic              cap_event;
  logic              cap_int;
  logic [DATA_W-1:0] cap_value;
  logic              popped;
  logic [3:0]        presc_last;

  assign mode = s_reg.ctrl.capture_mode_select;

  always_comb begin
    s_next     = s_reg;
    halted     = s_reg.ctrl.stop_in_idle && power.cpu_idle;
    rise       = cap_pin && !s_reg.pin_prev;
    fall       = !cap_pin && s_reg.pin_prev;
    cap_event  = 1'b0;
    cap_int    = 1'b0;
    popped     = 1'b0;
    presc_last = (mode == MODE_RISE_16) ? PRESC_LAST_16 : PRESC_LAST_4;
    cap_value  = s_reg.ctrl.timer_select ? second_general_timer
                                         : third_general_timer;

    s_next.pin_prev = cap_pin;
    s_next.rdata    = RST_DATA;

    // -------------------------------------------------------------------------
    // Register reads
    // -------------------------------------------------------------------------
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_CTRL: begin
          s_next.rdata = ctrl_image(s_reg);
        end
        ADDR_CAPBUF: begin
          if (s_reg.count != '0) begin
            s_next.rdata  = s_reg.fifo[s_reg.rd_ptr];
            s_next.rd_ptr = ptr_inc(s_reg.rd_ptr);
            s_next.count  = s_reg.count - CNT_W'(1);
            popped        = 1'b1;
          end
        end
        ADDR_INT_STAT: begin
          s_next.rdata             = {{(DATA_W-INT_W){1'b0}}, s_reg.int_status};
          s_next.int_status        = RST_INT;
        end
        ADDR_INT_MASK: begin
          s_next.rdata             = {{(DATA_W-INT_W){1'b0}}, s_reg.int_mask};
        end
      endcase
    end

    // -------------------------------------------------------------------------
    // Register writes; flag bits are not writable
    // -------------------------------------------------------------------------
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        ADDR_CTRL: begin
          s_next.ctrl.stop_in_idle           = bus_req.wdata[BIT_STOP_IDLE];
          s_next.ctrl.timer_select           = bus_req.wdata[BIT_TMR_SEL];
          s_next.ctrl.captures_per_interrupt = bus_req.wdata[BIT_CPI_HI:BIT_CPI_LO];
          s_next.ctrl.capture_mode_select    = bus_req.wdata[BIT_MODE_HI:BIT_MODE_LO];
          // Mode change restarts the edge and capture counting
          if (bus_req.wdata[BIT_MODE_HI:BIT_MODE_LO] != mode) begin
            s_next.presc = '0;
            s_next.decim = '0;
          end
          // Switching off flushes the buffer and its flags
          if (mode_is_off(bus_req.wdata[BIT_MODE_HI:BIT_MODE_LO])) begin
            s_next.count    = '0;
            s_next.rd_ptr   = s_next.wr_ptr;
            s_next.overflow = 1'b0;
          end
        end
        ADDR_INT_MASK: begin
          s_next.int_mask = bus_req.wdata[INT_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // -------------------------------------------------------------------------
    // Edge qualification per mode
    // -------------------------------------------------------------------------
    if (mode == MODE_WAKE) begin
      // Other control bits, idle halt included, do not apply here
      if (rise && (power.cpu_sleep || power.cpu_idle)) begin
        s_next.int_status[INT_WAKE] = 1'b1;
      end
    end else if (!halted && !mode_is_off(mode)) begin
      unique case (mode)
        MODE_EVERY_EDGE: cap_event = rise || fall;
        MODE_FALL:       cap_event = fall;
        MODE_RISE:       cap_event = rise;
        MODE_RISE_4, MODE_RISE_16: begin
          if (rise) begin
            if (s_reg.presc >= presc_last) begin
              cap_event    = 1'b1;
              s_next.presc = '0;
            end else begin
              s_next.presc = s_reg.presc + 4'h1;
            end
          end
        end
        default: cap_event = 1'b0;
      endcase
    end

    // -------------------------------------------------------------------------
    // Capture into buffer, overflow and interrupt decimation
    // -------------------------------------------------------------------------
    if (cap_event) begin
      if (s_next.count < FIFO_FULL_CNT) begin
        s_next.fifo[s_next.wr_ptr] = cap_value;
        s_next.wr_ptr              = ptr_inc(s_next.wr_ptr);
        s_next.count               = s_next.count + CNT_W'(1);
      end else begin
        // Value is dropped; older entries are kept
        s_next.overflow                 = 1'b1;
        s_next.int_status[INT_OVERFLOW] = 1'b1;
      end
      if (mode == MODE_EVERY_EDGE) begin
        cap_int = 1'b1;
      end else if (s_reg.decim >= s_reg.ctrl.captures_per_interrupt) begin
        cap_int      = 1'b1;
        s_next.decim = '0;
      end else begin
        s_next.decim = s_reg.decim + 2'h1;
      end
    end
    if (cap_int) begin
      s_next.int_status[INT_CAPTURE] = 1'b1;
    end

    // Overflow clears once software has drained the buffer
    if (popped && (s_next.count == '0) && !cap_event) begin
      s_next.overflow = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Registered state
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign irq       = |(s_reg.int_status & s_reg.int_mask);

endmodule

// [bench/icc_pin_model.sv]
// Behavioural source driving the capture pin with bursts of level changes
module icc_pin_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       slow,
  input  wire logic [5:0] edges,
  output logic            cap_pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] left;
  logic [1:0] hold;
  // Slow holds each level four cycles, fast two; even bursts end low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cap_pin <= 1'b0;
      left    <= 6'h0;
      hold    <= 2'h0;
    end else if (start) begin
      left <= edges;
      hold <= 2'h0;
    end else if (left != 6'h0) begin
      hold <= hold + 2'h1;
      if (hold == {slow, 1'b1}) begin
        cap_pin <= ~cap_pin;
        left    <= left - 6'h1;
        hold    <= 2'h0;
      end
    end
  end
  assign busy = left != 6'h0;
endmodule

// [bench/icc_capture_asserts.sv]
// Port-level checks for the capture channel
module icc_capture_asserts
  import icc_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire icc_pkg::icc_bus_req_t       bus_req,
  input wire logic [icc_pkg::DATA_W-1:0]  reg_rdata,
  input wire logic                        cap_pin,
  input wire icc_pkg::icc_power_t         power,
  input wire logic                        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ctrl_reg;
  logic [2:0]  mask_reg;
  // Shadows of software writes, so checks know mode and mask
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= 16'h0;
      mask_reg <= 3'h0;
    end else if (bus_req.wr && bus_req.addr == ADDR_CTRL) begin
      ctrl_reg <= bus_req.wdata;
    end else if (bus_req.wr && bus_req.addr == ADDR_INT_MASK) begin
      mask_reg <= bus_req.wdata[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(logic [1:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  sequence s_off_wr;
    bus_req.wr && bus_req.addr == ADDR_CTRL && bus_req.wdata[2:0] == MODE_OFF;
  endsequence
  sequence s_edge;
    $rose(cap_pin) && !bus_req.wr;
  endsequence
  a_rdata_idle_zero: assert property (!bus_req.rd |=> reg_rdata == 16'h0)
    else $error("read data not zero outside a read");
  a_ctrl_unimpl_zero: assert property (s_rd(ADDR_CTRL) |=>
    reg_rdata[15:14] == 2'h0 && reg_rdata[12:8] == 5'h0) else $error("reserved bits set");
  a_ctrl_readback: assert property (s_rd(ADDR_CTRL) |=>
    {reg_rdata[13], reg_rdata[7:5], reg_rdata[2:0]} == {$past(ctrl_reg[13]),
    $past(ctrl_reg[7:5]), $past(ctrl_reg[2:0])}) else $error("control readback wrong");
  a_off_flushes: assert property (s_off_wr ##2 s_rd(ADDR_CTRL) |=>
    reg_rdata[4:3] == 2'h0) else $error("flags set after turning off");
  a_int_unimpl_zero: assert property (bus_req.rd && bus_req.addr[1] |=>
    reg_rdata[15:3] == 13'h0) else $error("interrupt register upper bits set");
  a_mask_gates_irq: assert property (mask_reg == 3'h0 |-> !irq)
    else $error("interrupt with all sources masked");
  a_rise_irq: assert property (ctrl_reg[2:0] == MODE_RISE && ctrl_reg[6:5] == 2'h0 &&
    mask_reg[1:0] == 2'h3 && !(ctrl_reg[13] && power.cpu_idle) ##0 s_edge |=> irq)
    else $error("rising edge raised no interrupt");
  a_wake_irq: assert property (ctrl_reg[2:0] == MODE_WAKE && mask_reg[2] &&
    (power.cpu_sleep || power.cpu_idle) ##0 s_edge |=> irq) else $error("no wake interrupt");
endmodule

bind icc_capture icc_capture_asserts i_chk (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
  .reg_rdata(reg_rdata), .cap_pin(cap_pin), .power(power), .irq(irq));

// [bench/tb.sv]
// Self-checking bench for the input capture channel
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import icc_pkg::*;
  logic         clk, rst_n, start, slow, busy, cap_pin, irq;
  logic [5:0]   edges;
  logic [15:0]  rdata, d;
  icc_bus_req_t bus_req;
  icc_power_t   power;
  int           err_count, n_tests, n;
  int           ncap [8] = '{0, 4, 4, 4, 4, 1, 0, 0};
  logic [7:0]   ovf_m = 8'h0e;
  icc_capture i_dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .reg_rdata(rdata),
    .cap_pin(cap_pin), .second_general_timer(16'ha5c3), .third_general_timer(16'h5a3c),
    .power(power), .irq(irq));
  icc_pin_model i_pin (.clk(clk), .rst_n(rst_n), .start(start), .slow(slow),
    .edges(edges), .cap_pin(cap_pin), .busy(busy));
  always #5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    bus_req.addr  <= a;
    bus_req.wdata <= v;
    bus_req.wr    <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] q);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    q = rdata;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [1:0] a, input logic [15:0] exp);
    logic [15:0] q;
    rd(a, q);
    chk(q, exp);
  endtask
  task automatic pulses(input logic [5:0] k);
    edges <= k;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 300 && busy; i++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    start = 1'b0;
    slow = 1'b0;
    edges = 6'h0;
    bus_req = '0;
    power = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, 16'hffe0);
    rdc(ADDR_CTRL, 16'h20e0);
    wr(ADDR_INT_MASK, 16'hffff);
    rdc(ADDR_INT_MASK, 16'h0007);
    wr(ADDR_CAPBUF, 16'hffff);
    rdc(ADDR_CAPBUF, 16'h0000);
    wr(ADDR_CTRL, 16'h0083);
    pulses(6'h2);
    wr(ADDR_CTRL, 16'h0002);
    pulses(6'h2);
    // Both captures queued; they must come out oldest first
    rdc(ADDR_CAPBUF, 16'ha5c3);
    rdc(ADDR_CAPBUF, 16'h5a3c);
    $display("registers and timer select done");
    for (int m = 0; m < 8; m++) begin
      slow <= m[0];
      wr(ADDR_CTRL, 16'h0000);
      wr(ADDR_CTRL, {13'h0, 3'(m)});
      rd(ADDR_INT_STAT, d);
      pulses(6'h20);
      rdc(ADDR_CTRL, {11'h0, ovf_m[m], ncap[m] != 0, 3'(m)});
      rdc(ADDR_INT_STAT, {14'h0, ovf_m[m], ncap[m] != 0});
      n = 0;
      repeat (6) begin
        rd(ADDR_CTRL, d);
        if (d[3] === 1'b1) begin
          rd(ADDR_CAPBUF, d);
          n++;
        end
      end
      chk(16'(n), 16'(ncap[m]));
    end
    $display("mode table done");
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL, 16'h0000);
      wr(ADDR_CTRL, {9'h0, 2'(c), 2'h0, MODE_RISE});
      rd(ADDR_INT_STAT, d);
      for (int p = 1; p <= 4; p++) begin
        pulses(6'h2);
        rdc(ADDR_INT_STAT, {15'h0, (p % (c + 1)) == 0});
      end
    end
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, {9'h0, 2'h3, 2'h0, MODE_EVERY_EDGE});
    rd(ADDR_INT_STAT, d);
    pulses(6'h2);
    chk({15'h0, irq}, 16'h0001);
    wr(ADDR_INT_MASK, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    wr(ADDR_INT_MASK, 16'h0007);
    rdc(ADDR_INT_STAT, 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    $display("decimation and interrupt done");
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, 16'h2003);
    power.cpu_idle <= 1'b1;
    pulses(6'h2);
    rdc(ADDR_CTRL, 16'h2003);
    wr(ADDR_CTRL, 16'h0003);
    pulses(6'h2);
    rdc(ADDR_CTRL, 16'h000b);
    wr(ADDR_CTRL, 16'h0000);
    rdc(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, 16'h0007);
    rd(ADDR_INT_STAT, d);
    pulses(6'h2);
    rdc(ADDR_INT_STAT, 16'h0004);
    rdc(ADDR_CTRL, 16'h0007);
    $display("idle and wake done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule
